// file: core/servo_protection_alarms_defines.svh
// What this block does
// - A bad function assignment on the three latch-correction pins raises alarm 33 sub 8.
// - The latch alarm is flagged when trigger A is not on input five or trigger B not on six.
// - The latch alarm is flagged for origin on six or seven, positive limit on five or seven, negative limit on five or six.
// - The latch alarm is flagged when a latch-pin function uses normally-closed contact logic.
// - The latch alarm is flagged when a latch-pin function is unassigned in any control mode.
// - Position outside the working range raises alarm 34 sub 0, and a range of zero disables it.
// - Corrupted parameter storage found at power-on raises alarm 36 with sub 0, 1 or 2.
// - Corrupted write-check data found at power-on raises alarm 37 with sub 0, 1 or 2.
// - With travel-inhibit setting 0, both limit inputs active together raise alarm 38 sub 0.
// - With travel-inhibit setting 2, either limit input active raises alarm 38 sub 0.
// - With setting 0 or 1, a service command with link off and a limit active, or a limit rising during service operation, raises 38 sub 1.
// - Positive limit on input six or negative limit on input seven with setting not 1 raises 38 sub 2.
// - Encoder backup supply collapse raises alarm 40 sub 0, held until the absolute encoder is cleared.
// - Multi-turn counter overflow of the absolute encoder raises alarm 41 sub 0.
// - An incremental encoder initialization failure raises alarm 43 sub 0.
`ifndef SERVO_PROTECTION_ALARMS_DEFINES_SVH
`define SERVO_PROTECTION_ALARMS_DEFINES_SVH

// ==========================================================
// Register map
`define OFS_CTRL   12'h000
`define OFS_MAP    12'h004
`define OFS_MODE   12'h008
`define OFS_RANGE  12'h00C
`define OFS_STS    12'h010
`define OFS_MASK   12'h014
`define OFS_ALARM  12'h018

// ==========================================================
// Fields
`define CTRL_SET_LO   0
`define CTRL_CLR      8
`define CTRL_ABS_CLR  9
`define MAP_NC_LO     10
`define ALARM_VALID   16
`define MODE_ALL      3'h7

`define PIN_NONE   2'h0
`define PIN_FIVE   2'h1
`define PIN_SIX    2'h2
`define PIN_SEVEN  2'h3

`define FN_A     0
`define FN_B     1
`define FN_ORG   2
`define FN_POS   3
`define FN_NEG   4
`define NFN      5

// ==========================================================
// Fault indices, lowest index has highest priority
`define F_LATCH    0
`define F_RANGE    1
`define F_PARAM    2
`define F_CHECK    3
`define F_OT_LIM   4
`define F_OT_SVC   5
`define F_OT_MAP   6
`define F_ABS_DN   7
`define F_ABS_CNT  8
`define F_ABS_OVS  9
`define F_INC_INI  10
`define NFAULT     11

// ==========================================================
// Alarm numbers
`define M_LATCH    8'h21
`define M_RANGE    8'h22
`define M_PARAM    8'h24
`define M_CHECK    8'h25
`define M_OT       8'h26
`define M_ABS_DN   8'h28
`define M_ABS_CNT  8'h29
`define M_ABS_OVS  8'h2A
`define M_INC_INI  8'h2B
`define S_LATCH    8'h08

`endif

// file: core/servo_protection_alarms_pkg.sv
`include "servo_protection_alarms_defines.svh"

package servo_protection_alarms_pkg;

    // ======================================================
    // Carriers
    typedef struct packed {
        logic [7:0] main;
        logic [7:0] sub;
    } alarm_code_t;

    typedef struct packed {
        logic backup_fail;
        logic multiturn_over;
        logic batt_overspeed;
        logic inc_init_fail;
    } enc_status_t;

    typedef struct packed {
        logic       done;
        logic       param_bad;
        logic [1:0] param_sub;
        logic       check_bad;
        logic [1:0] check_sub;
    } nvm_report_t;

    typedef logic [`NFAULT-1:0] fault_vec_t;

endpackage : servo_protection_alarms_pkg

// file: core/servo_protection_alarms.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "servo_protection_alarms_defines.svh"

module servo_protection_alarms
    import servo_protection_alarms_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pos_limit_pin,
    input  wire logic        neg_limit_pin,
    input  wire logic        link_up,
    input  wire logic        svc_cmd,
    input  wire logic        svc_active,
    input  wire logic [31:0] motor_pos,
    input  wire nvm_report_t nvm,
    input  wire enc_status_t enc,
    output alarm_code_t      alarm,
    output logic             alarm_valid,
    output logic             abs_clear,
    output logic             alarm_irq
);

    // ======================================================
    // Decoding helpers
    function automatic logic [1:0] pin_of(
        input logic [9:0] m,
        input int         fn
    );
        pin_of = m[2*fn +: 2];
    endfunction : pin_of

    function automatic alarm_code_t code_of(
        input int         idx,
        input logic [1:0] psub,
        input logic [1:0] csub
    );
        alarm_code_t c;
        c = '{main: 8'h00, sub: 8'h00};
        case (idx)
            `F_LATCH:   c = '{main: `M_LATCH, sub: `S_LATCH};
            `F_RANGE:   c = '{main: `M_RANGE, sub: 8'h00};
            `F_PARAM:   c = '{main: `M_PARAM, sub: {6'h00, psub}};
            `F_CHECK:   c = '{main: `M_CHECK, sub: {6'h00, csub}};
            `F_OT_LIM:  c = '{main: `M_OT, sub: 8'h00};
            `F_OT_SVC:  c = '{main: `M_OT, sub: 8'h01};
            `F_OT_MAP:  c = '{main: `M_OT, sub: 8'h02};
            `F_ABS_DN:  c = '{main: `M_ABS_DN, sub: 8'h00};
            `F_ABS_CNT: c = '{main: `M_ABS_CNT, sub: 8'h00};
            `F_ABS_OVS: c = '{main: `M_ABS_OVS, sub: 8'h00};
            `F_INC_INI: c = '{main: `M_INC_INI, sub: 8'h00};
            default:    c = '{main: 8'h00, sub: 8'h00};
        endcase
        code_of = c;
    endfunction : code_of

    // ======================================================
    // Registers
    logic [1:0]     set_ff;
    logic [9:0]     map_ff;
    logic [4:0]     nc_ff;
    logic [14:0]    mode_ff;
    logic [31:0]    range_ff;
    fault_vec_t     sts_ff;
    fault_vec_t     mask_ff;
    alarm_code_t    alarm_ff;
    logic           valid_ff;
    logic           abs_clr_ff;
    logic [31:0]    rdata_ff;
    logic           param_bad_ff;
    logic           check_bad_ff;
    logic [1:0]     psub_ff;
    logic [1:0]     csub_ff;
    logic           abs_dn_ff;
    logic           abs_ovs_ff;
    logic           pos_s1_ff;
    logic           pos_s2_ff;
    logic           neg_s1_ff;
    logic           neg_s2_ff;
    logic           lim_prev_ff;

    // ======================================================
    // Bus decode
    wire            setup    = psel && !penable;
    wire            access   = psel && penable;
    wire            hit_ctrl = paddr == `OFS_CTRL;
    wire            hit_map  = paddr == `OFS_MAP;
    wire            hit_mode = paddr == `OFS_MODE;
    wire            hit_rng  = paddr == `OFS_RANGE;
    wire            hit_sts  = paddr == `OFS_STS;
    wire            hit_mask = paddr == `OFS_MASK;
    wire            hit_alm  = paddr == `OFS_ALARM;
    wire            mapped   = hit_ctrl | hit_map | hit_mode | hit_rng
                             | hit_sts | hit_mask | hit_alm;
    wire            wr       = access && pwrite && mapped;
    wire            wr_ctrl  = wr && hit_ctrl;
    wire            rd_sts   = access && !pwrite && hit_sts;
    wire            clr_req  = wr_ctrl && pwdata[`CTRL_CLR];
    wire            abs_req  = wr_ctrl && pwdata[`CTRL_ABS_CLR];

    wire [31:0]     rd_word =
          hit_ctrl ? {30'h0000_0000, set_ff}
        : hit_map  ? {17'h0_0000, nc_ff, map_ff}
        : hit_mode ? {17'h0_0000, mode_ff}
        : hit_rng  ? range_ff
        : hit_sts  ? {21'h00_0000, sts_ff}
        : hit_mask ? {21'h00_0000, mask_ff}
        : hit_alm  ? {15'h0000, valid_ff, alarm_ff}
        : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = rdata_ff;

    // ======================================================
    // Limit pin synchronisers
    wire            pos_lim = pos_s2_ff;
    wire            neg_lim = neg_s2_ff;
    wire            lim_any = pos_lim || neg_lim;
    wire            lim_rise = lim_any && !lim_prev_ff;

    // ======================================================
    // Latch-pin assignment checks
    wire [1:0]      pin_a   = pin_of(map_ff, `FN_A);
    wire [1:0]      pin_b   = pin_of(map_ff, `FN_B);
    wire [1:0]      pin_org = pin_of(map_ff, `FN_ORG);
    wire [1:0]      pin_pos = pin_of(map_ff, `FN_POS);
    wire [1:0]      pin_neg = pin_of(map_ff, `FN_NEG);

    wire            bad_trig = pin_a != `PIN_FIVE
                            || pin_b != `PIN_SIX;
    wire            bad_pos  = (pin_org == `PIN_SIX)
                            || (pin_org == `PIN_SEVEN)
                            || (pin_pos == `PIN_FIVE)
                            || (pin_pos == `PIN_SEVEN)
                            || (pin_neg == `PIN_FIVE)
                            || (pin_neg == `PIN_SIX);

    logic [`NFN-1:0] nc_bad;
    logic [`NFN-1:0] mode_bad;

    genvar g;
    generate
        for (g = 0; g < `NFN; g++) begin : g_fn
            wire on_latch = pin_of(map_ff, g) != `PIN_NONE;
            assign nc_bad[g]   = on_latch && nc_ff[g];
            assign mode_bad[g] = on_latch
                              && mode_ff[3*g +: 3] != `MODE_ALL;
        end
    endgenerate

    // Any of the four causes shares one alarm code.
    wire            latch_err = bad_trig || bad_pos
                             || (|nc_bad) || (|mode_bad);

    // ======================================================
    // Working range and travel-inhibit checks
    wire [31:0]     pos_neg = ~motor_pos + 32'h0000_0001;
    wire [31:0]     pos_mag = motor_pos[31] ? pos_neg : motor_pos;
    wire            range_err = (range_ff != 32'h0000_0000)
                             && (pos_mag > range_ff);

    wire            ot_lim = (set_ff == 2'h0 && pos_lim && neg_lim)
                          || (set_ff == 2'h2 && lim_any);
    wire            svc_mode = set_ff == 2'h0 || set_ff == 2'h1;
    wire            ot_svc = svc_mode
                          && ((svc_cmd && !link_up && lim_any)
                          ||  (svc_active && lim_rise));
    wire            ot_map = set_ff != 2'h1
                          && (pin_pos == `PIN_SIX || pin_neg == `PIN_SEVEN);

    // ======================================================
    // Fault vector and priority select
    fault_vec_t     cond;

    assign cond[`F_LATCH]   = latch_err;
    assign cond[`F_RANGE]   = range_err;
    assign cond[`F_PARAM]   = param_bad_ff;
    assign cond[`F_CHECK]   = check_bad_ff;
    assign cond[`F_OT_LIM]  = ot_lim;
    assign cond[`F_OT_SVC]  = ot_svc;
    assign cond[`F_OT_MAP]  = ot_map;
    assign cond[`F_ABS_DN]  = abs_dn_ff || enc.backup_fail;
    assign cond[`F_ABS_CNT] = enc.multiturn_over;
    assign cond[`F_ABS_OVS] = abs_ovs_ff || enc.batt_overspeed;
    assign cond[`F_INC_INI] = enc.inc_init_fail;

    wire            any_cond = |cond;

    alarm_code_t    first_code;

    always_comb begin
        first_code = '{main: 8'h00, sub: 8'h00};
        for (int i = `NFAULT - 1; i >= 0; i--) begin
            if (cond[i]) begin
                first_code = code_of(i, psub_ff, csub_ff);
            end
        end
    end

    // A clear only succeeds while no cause is still present, so a cause present
    // in the clearing cycle keeps the alarm standing; a limit pin change or storage report arriving then counts only once registered.
    wire            clr_ok = clr_req && !any_cond;

    alarm_code_t    nxt_alarm;
    logic           nxt_valid;

    assign nxt_valid = valid_ff ? !clr_ok : any_cond;
    assign nxt_alarm = (!valid_ff && any_cond) ? first_code : alarm_ff;

    // Sticky status: the set term is ORed last so it wins over a read-clear.
    fault_vec_t     nxt_sts;
    assign nxt_sts = (rd_sts ? '0 : sts_ff) | cond;

    assign alarm       = alarm_ff;
    assign alarm_valid = valid_ff;
    assign abs_clear   = abs_clr_ff;
    assign alarm_irq   = |(sts_ff & mask_ff);

    // ======================================================
    // Software registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            set_ff   <= 2'h0;
            map_ff   <= 10'h000;
            nc_ff    <= 5'h00;
            mode_ff  <= 15'h0000;
            range_ff <= 32'h0000_0000;
            mask_ff  <= '0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            if (wr_ctrl)
                set_ff <= pwdata[`CTRL_SET_LO +: 2];
            if (wr && hit_map) begin
                map_ff <= pwdata[9:0];
                nc_ff  <= pwdata[`MAP_NC_LO +: `NFN];
            end
            if (wr && hit_mode)
                mode_ff <= pwdata[14:0];
            if (wr && hit_rng)
                range_ff <= pwdata;
            if (wr && hit_mask)
                mask_ff <= pwdata[`NFAULT-1:0];
            if (setup && !pwrite)
                rdata_ff <= rd_word;
        end
    end

    // ======================================================
    // Alarm state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sts_ff     <= '0;
            alarm_ff   <= '{main: 8'h00, sub: 8'h00};
            valid_ff   <= 1'b0;
            abs_clr_ff <= 1'b0;
        end else begin
            sts_ff     <= nxt_sts;
            alarm_ff   <= nxt_alarm;
            valid_ff   <= nxt_valid;
            abs_clr_ff <= abs_req;
        end
    end

    // Power-on storage results are captured on every cycle with nvm.done high and kept until reset,
    // since the corrupted data does not heal by itself.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            param_bad_ff <= 1'b0;
            check_bad_ff <= 1'b0;
            psub_ff      <= 2'h0;
            csub_ff      <= 2'h0;
        end else if (nvm.done) begin
            if (nvm.param_bad) begin
                param_bad_ff <= 1'b1;
                psub_ff      <= nvm.param_sub;
            end
            if (nvm.check_bad) begin
                check_bad_ff <= 1'b1;
                csub_ff      <= nvm.check_sub;
            end
        end
    end

    // Encoder battery faults hold until an absolute clear; a new report
    // in the clearing cycle wins.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            abs_dn_ff  <= 1'b0;
            abs_ovs_ff <= 1'b0;
        end else begin
            abs_dn_ff  <= enc.backup_fail
                       || (abs_dn_ff && !abs_req);
            abs_ovs_ff <= enc.batt_overspeed
                       || (abs_ovs_ff && !abs_req);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pos_s1_ff   <= 1'b0;
            pos_s2_ff   <= 1'b0;
            neg_s1_ff   <= 1'b0;
            neg_s2_ff   <= 1'b0;
            lim_prev_ff <= 1'b0;
        end else begin
            pos_s1_ff   <= pos_limit_pin;
            pos_s2_ff   <= pos_s1_ff;
            neg_s1_ff   <= neg_limit_pin;
            neg_s2_ff   <= neg_s1_ff;
            lim_prev_ff <= lim_any;
        end
    end

    // ======================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_idle_fault;
        !valid_ff && any_cond;
    endsequence

    sequence s_clear_ok;
        valid_ff && clr_req && !any_cond;
    endsequence

    property p_latch_code;
        !valid_ff && latch_err |=> valid_ff && alarm_ff.main == 8'h21
            && alarm_ff.sub == 8'h08;
    endproperty
    a_latch_code: assert property (p_latch_code)
        else $error("latch allocation alarm not 33.8");

    property p_trig_pin;
        pin_a != `PIN_FIVE |-> ##1 valid_ff;
    endproperty
    a_trig_pin: assert property (p_trig_pin)
        else $error("trigger A off input five not flagged");

    property p_range_off;
        range_ff == 32'h0000_0000 |-> !cond[`F_RANGE];
    endproperty
    a_range_off: assert property (p_range_off)
        else $error("range check active with zero range");

    property p_nvm_sub;
        nvm.done && nvm.param_bad && !nvm.check_bad
            |=> param_bad_ff && psub_ff == $past(nvm.param_sub);
    endproperty
    a_nvm_sub: assert property (p_nvm_sub)
        else $error("parameter storage sub code not captured");

    property p_ot_both;
        set_ff == 2'h0 && pos_lim && neg_lim |-> cond[`F_OT_LIM];
    endproperty
    a_ot_both: assert property (p_ot_both)
        else $error("both limits active not flagged");

    property p_ot_map;
        set_ff == 2'h1 |-> !cond[`F_OT_MAP];
    endproperty
    a_ot_map: assert property (p_ot_map)
        else $error("limit mapping alarm with setting 1");

    property p_abs_hold;
        abs_dn_ff && !abs_req |=> abs_dn_ff;
    endproperty
    a_abs_hold: assert property (p_abs_hold)
        else $error("backup fault released without clear");

    property p_hold;
        s_idle_fault ##1 (valid_ff && !clr_req) |=> valid_ff
            && $stable(alarm_ff);
    endproperty
    a_hold: assert property (p_hold)
        else $error("alarm code changed while latched");

    property p_clear;
        s_clear_ok |=> !valid_ff;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear without cause did not release alarm");

    property p_irq;
        sts_ff[`F_RANGE] && mask_ff[`F_RANGE] |-> alarm_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("unmasked status did not raise interrupt");

endmodule : servo_protection_alarms

// file: testbench/servo_far_side.sv
`timescale 1ns/1ps

module servo_far_side
    import servo_protection_alarms_pkg::*;
(
    input  wire logic        ref_clk,
    output logic             pos_limit_pin,
    output logic             neg_limit_pin,
    output logic             link_up,
    output logic             svc_cmd,
    output logic             svc_active,
    output logic      [31:0] motor_pos,
    output nvm_report_t      nvm,
    output enc_status_t      enc
);
    // ==========================================================
    // Switches, encoder and host channel
    initial begin
        pos_limit_pin = 1'b0;
        neg_limit_pin = 1'b0;
        link_up       = 1'b1;
        svc_cmd       = 1'b0;
        svc_active    = 1'b0;
        motor_pos     = 32'h0000_0000;
        nvm           = '0;
        enc           = '0;
    end

    task set_limits(input logic p, input logic n);
        @(posedge ref_clk);
        pos_limit_pin <= p;
        neg_limit_pin <= n;
    endtask : set_limits

    task set_env(input logic [31:0] pos, input logic link);
        @(posedge ref_clk);
        motor_pos <= pos;
        link_up   <= link;
    endtask : set_env

    task service(input logic cmd, input logic act);
        @(posedge ref_clk);
        svc_cmd    <= cmd;
        svc_active <= act;
        @(posedge ref_clk);
        svc_cmd    <= 1'b0;
    endtask : service

    task pulse_enc(input enc_status_t e);
        @(posedge ref_clk);
        enc <= e;
        @(posedge ref_clk);
        enc <= '0;
    endtask : pulse_enc

    task report(input nvm_report_t r);
        nvm_report_t idle_val;
        // Flags mean nothing without done, so they flip afterwards to expose late sampling.
        idle_val      = ~r;
        idle_val.done = 1'b0;
        @(posedge ref_clk);
        nvm <= r;
        @(posedge ref_clk);
        nvm <= idle_val;
    endtask : report
endmodule : servo_far_side

// file: testbench/servo_protection_alarms_test.sv
`timescale 1ns/1ps
`include "servo_protection_alarms_defines.svh"

module servo_protection_alarms_test
    import servo_protection_alarms_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pos_lim, neg_lim, link_up, svc_cmd, svc_act, alarm_valid, abs_clear, alarm_irq;
    logic [31:0] motor_pos;
    nvm_report_t nvm;
    enc_status_t enc;
    alarm_code_t alarm;
    int          miscompares, compares, cycles, pulses, k;
    logic [31:0] bad_map [8] = '{32'h0000_0008, 32'h0000_000D, 32'h0000_0029, 32'h0000_0049,
                                 32'h0000_00C9, 32'h0000_0109, 32'h0000_0409, 32'h0000_0009};
    logic [7:0]  enc_main [4] = '{`M_ABS_DN, `M_ABS_CNT, `M_ABS_OVS, `M_INC_INI};
    logic [7:0]  lim_tab [4] = '{8'h02, 8'h13, 8'h25, 8'h07};
    localparam logic [31:0] MAP_OK  = 32'h0000_0009;
    localparam logic [31:0] MODE_OK = 32'h0000_7FFF;

    always #12.5 ref_clk = ~ref_clk;

    servo_protection_alarms u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pos_limit_pin(pos_lim), .neg_limit_pin(neg_lim),
        .link_up(link_up), .svc_cmd(svc_cmd), .svc_active(svc_act), .motor_pos(motor_pos),
        .nvm(nvm), .enc(enc), .alarm(alarm), .alarm_valid(alarm_valid),
        .abs_clear(abs_clear), .alarm_irq(alarm_irq));

    servo_far_side u_far (.ref_clk(ref_clk), .pos_limit_pin(pos_lim), .neg_limit_pin(neg_lim),
        .link_up(link_up), .svc_cmd(svc_cmd), .svc_active(svc_act), .motor_pos(motor_pos),
        .nvm(nvm), .enc(enc));

    // ==========================================================
    // Helpers
    task print_verdict;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : idle

    // The request stays put until pready is seen high at a rising edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task chk_valid(input logic v);
        // A cause seen at one edge shows on alarm_valid only after the next one.
        idle(2);
        check("alarm_valid", {31'h0, v}, {31'h0, alarm_valid});
    endtask : chk_valid

    task expect_alarm(input logic [7:0] m, input logic [7:0] s);
        apb(1'b0, `OFS_ALARM, 32'h0000_0000);
        check("alarm_reg", {15'h0, 1'b1, m, s}, rd);
        check("alarm_port", {16'h0, m, s}, {16'h0, alarm});
    endtask : expect_alarm

    task clear(input logic [1:0] set, input logic v);
        apb(1'b1, `OFS_CTRL, 32'h0000_0100 | {30'h0, set});
        apb(1'b0, `OFS_STS, 32'h0000_0000);
        chk_valid(v);
    endtask : clear

    task setup_pins;
        apb(1'b1, `OFS_MAP, MAP_OK);
        apb(1'b1, `OFS_MODE, MODE_OK);
        clear(2'd0, 1'b0);
    endtask : setup_pins

    always @(posedge ref_clk) begin
        cycles++;
        if (abs_clear === 1'b1)
            pulses++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ==========================================================
    // Scenarios
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {miscompares, compares, cycles, pulses} = '0;
        idle(4);
        rst_n <= 1'b1;
        idle(2);
        expect_alarm(`M_LATCH, `S_LATCH);
        apb(1'b0, `OFS_STS, 32'h0000_0000);
        check("sts", 32'h0000_0001, rd);
        apb(1'b1, `OFS_MASK, 32'h0000_0000);
        chk_valid(1'b1);
        check("irq_masked", 32'h0, {31'h0, alarm_irq});
        apb(1'b1, `OFS_MASK, 32'h0000_07FF);
        idle(1);
        check("irq_open", 32'h1, {31'h0, alarm_irq});
        apb(1'b0, 12'h01C, 32'h0000_0000);
        check("unmapped", 32'h1, {rd[30:0], err});
        setup_pins();
        check("irq_cleared", 32'h0, {31'h0, alarm_irq});
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `OFS_MAP, bad_map[i]);
            apb(1'b1, `OFS_MODE, (i == 7) ? 32'h0000_7FFE : MODE_OK);
            expect_alarm(`M_LATCH, `S_LATCH);
            setup_pins();
        end
        u_far.set_env(32'h7FFF_0000, 1'b1);
        apb(1'b1, `OFS_RANGE, 32'h0000_0000);
        chk_valid(1'b0);
        u_far.set_env(32'h0000_0064, 1'b1);
        apb(1'b1, `OFS_RANGE, 32'h0000_0064);
        chk_valid(1'b0);
        u_far.set_env(32'hFFFF_FF9B, 1'b1);
        expect_alarm(`M_RANGE, 8'h00);
        u_far.set_env(32'h0000_0000, 1'b1);
        clear(2'd0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_CTRL, {30'h0, lim_tab[i][5:4]});
            u_far.set_limits(lim_tab[i][1], lim_tab[i][0]);
            idle(4);
            if (lim_tab[i][2])
                expect_alarm(`M_OT, 8'h00);
            else
                chk_valid(1'b0);
            u_far.set_limits(1'b0, 1'b0);
            idle(3);
            clear(lim_tab[i][5:4], 1'b0);
        end
        apb(1'b1, `OFS_CTRL, 32'h0000_0001);
        u_far.set_env(32'h0000_0000, 1'b0);
        u_far.set_limits(1'b1, 1'b0);
        idle(3);
        u_far.service(1'b1, 1'b1);
        expect_alarm(`M_OT, 8'h01);
        u_far.set_limits(1'b0, 1'b0);
        idle(3);
        clear(2'd1, 1'b0);
        u_far.set_limits(1'b0, 1'b1);
        idle(3);
        expect_alarm(`M_OT, 8'h01);
        u_far.set_limits(1'b0, 1'b0);
        u_far.service(1'b0, 1'b0);
        u_far.set_env(32'h0000_0000, 1'b1);
        idle(3);
        clear(2'd0, 1'b0);
        apb(1'b1, `OFS_MAP, 32'h0000_0089);
        expect_alarm(`M_OT, 8'h02);
        setup_pins();
        k = 0;
        for (int i = 0; i < 4; i++) begin
            u_far.pulse_enc(enc_status_t'(4'b1000 >> i));
            expect_alarm(enc_main[i], 8'h00);
            if (i == 0 || i == 2) begin
                clear(2'd0, 1'b1);
                apb(1'b1, `OFS_CTRL, 32'h0000_0200);
                idle(2);
                k++;
                check("abs_clear", k, pulses);
            end
            clear(2'd0, 1'b0);
        end
        u_far.report('{done: 1'b1, param_bad: 1'b1, param_sub: 2'd2, default: '0});
        expect_alarm(`M_PARAM, 8'h02);
        clear(2'd0, 1'b1);
        rst_n <= 1'b0;
        idle(2);
        rst_n <= 1'b1;
        setup_pins();
        u_far.report('{done: 1'b1, check_bad: 1'b1, check_sub: 2'd1, default: '0});
        expect_alarm(`M_CHECK, 8'h01);
        print_verdict();
    end
endmodule : servo_protection_alarms_test
